// ==== rtl/dstc_pkg.sv ====
// dstc_pkg: constants, types and decode tables for the status block
// assumes a 200 MHz core clock and a 4-bit register index space
package dstc_pkg;

  // register indices
  localparam logic [3:0] IDX_MODE = 4'h0;
  localparam logic [3:0] IDX_HDR_LOW = 4'h8;
  localparam logic [3:0] IDX_HDR_HIGH = 4'h9;
  localparam logic [3:0] IDX_ATTEN = 4'hB;

  // mode register fields
  localparam int MODE_SWRST_BIT = 2;
  localparam int MODE_TEST_BIT = 5;
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // reset values
  localparam logic [15:0] HDR_RESET = 16'h0000;
  localparam logic [15:0] ATTEN_RESET = 16'h0000;

  // header fields and fixed values
  localparam logic [10:0] SYNC_VALID = 11'h7FF;
  localparam logic [15:0] WAV_LOW = 16'h7761;
  localparam logic [15:0] WAV_HIGH = 16'h7665;
  localparam logic [7:0] ATTEN_SILENT = 8'hFF;
  localparam logic [7:0] ATTEN_MAX_VALID = 8'hBF;
  localparam logic [31:0] PCM_LEN_FOREVER = 32'h0FFF_FFFF;
  localparam int MEM_DONE_BIT = 15;

  // command sequences and operand decoding
  localparam logic [23:0] CMD_SINE_HEAD = 24'h53_EF6E;
  localparam logic [31:0] CMD_SINE_EXIT = 32'h4578_6974;
  localparam logic [31:0] CMD_PIN = 32'h50ED_6E54;
  localparam logic [31:0] CMD_PROD = 32'hCB72_6B54;
  localparam logic [31:0] CMD_MEM = 32'h4DEA_6D54;
  localparam logic [23:0] CMD_COPY_HEAD = 24'h53_70EE;
  localparam logic [7:0] COPY_BASE = 8'h30;
  localparam int SINE_SKIP_SHIFT = 7;

  // cycle counts and widths
  localparam logic [12:0] SWRST_HOLD_CYC = 13'h1770;
  localparam int MEM_TEST_CYC = 32'h0003_0D40;
  localparam int MEM_CNT_W = 18;
  localparam int SYNC_W = 3;

  typedef enum logic [2:0] {
    TEST_NONE, TEST_SINE, TEST_PIN, TEST_PROD, TEST_MEM
  } dstc_test_t;

  // sample rate in Hz from version and rate code
  function automatic logic [16:0] rate_hz(input logic [1:0] ver,
                                         input logic [1:0] code);
    logic [16:0] base;
    base = 17'h0_0000;
    case (code)
      2'd0: base = 17'h0_AC44;
      2'd1: base = 17'h0_BB80;
      2'd2: base = 17'h0_7D00;
      default: base = 17'h0_0000;
    endcase
    if (ver == 2'd3) rate_hz = base;
    else if (ver == 2'd2) rate_hz = base >> 1;
    else rate_hz = base >> 2;
  endfunction : rate_hz

  // bitrate in kbit/s, zero for codes 0 and 15
  function automatic logic [8:0] rate_kbps(input logic [1:0] ver,
                                          input logic [3:0] code);
    logic [8:0] hi;
    logic [8:0] lo;
    hi = 9'h000;
    lo = 9'h000;
    case (code)
      4'd1: begin hi = 9'h020; lo = 9'h008; end
      4'd2: begin hi = 9'h028; lo = 9'h010; end
      4'd3: begin hi = 9'h030; lo = 9'h018; end
      4'd4: begin hi = 9'h038; lo = 9'h020; end
      4'd5: begin hi = 9'h040; lo = 9'h028; end
      4'd6: begin hi = 9'h050; lo = 9'h030; end
      4'd7: begin hi = 9'h060; lo = 9'h038; end
      4'd8: begin hi = 9'h070; lo = 9'h040; end
      4'd9: begin hi = 9'h080; lo = 9'h050; end
      4'd10: begin hi = 9'h0A0; lo = 9'h060; end
      4'd11: begin hi = 9'h0C0; lo = 9'h070; end
      4'd12: begin hi = 9'h0E0; lo = 9'h080; end
      4'd13: begin hi = 9'h100; lo = 9'h090; end
      4'd14: begin hi = 9'h140; lo = 9'h0A0; end
      default: begin hi = 9'h000; lo = 9'h000; end
    endcase
    rate_kbps = (ver == 2'd3) ? hi : lo;
  endfunction : rate_kbps

  // sine test rate from its 3-bit index
  function automatic logic [16:0] sine_rate(input logic [2:0] idx);
    case (idx)
      3'd0: sine_rate = 17'h0_AC44;
      3'd1: sine_rate = 17'h0_BB80;
      3'd2: sine_rate = 17'h0_7D00;
      3'd3: sine_rate = 17'h0_5622;
      3'd4: sine_rate = 17'h0_5DC0;
      3'd5: sine_rate = 17'h0_3E80;
      3'd6: sine_rate = 17'h0_2B11;
      default: sine_rate = 17'h0_2EE0;
    endcase
  endfunction : sine_rate

endpackage : dstc_pkg

// ==== rtl/dstc_sync.sv ====
// dstc_sync: three-stage synchroniser with agreement filter
// assumes inputs are asynchronous to clk
module dstc_sync
  import dstc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // async in, filtered level out
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] level_out
);

  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] lvl_q;
  logic [SYNC_W-1:0] lvl_d;

  // a change counts once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < SYNC_W; i++)
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;

endmodule : dstc_sync

// ==== rtl/dstc_top.sv ====
// dstc_top: header status, volume, reset timing and serial test commands
// assumes a decoder core beside it and a serial control front end
// that delivers register index, strobes and 16-bit data
//
// Contract
// [R1] upper header register: sync 15:5, version 4:3, layer 2:1, protect 0
// [R2] any reset loads zero into both header registers
// [R3] rate code 0..2 maps to 44100/48000/32000, halved or quartered
// [R4] bitrate codes 1..14 decode per version; 0 and 15 give no rate
// [R5] during wav decoding header registers read fixed values
// [R6] severe decode error clears header registers and mutes outputs
// [R7] each channel byte is attenuation in half dB steps, 255 silent
// [R8] volume register: left in upper byte, right in lower byte
// [R9] volume starts at full after power-up, kept over software reset
// [R10] both channels silent switches analog power off
// [R11] hardware reset clears all state, stops clocks, grounds crystal
// [R12] after software reset data request stays low 6000 cycles or more
// [R13] host sets reset bit, waits 2 us, resumes when request is high
// [R14] wav length 0 or 0xFFFFFFF keeps pcm mode indefinitely
// [R15] host resets, enables tests, sends 4 command bytes and 4 zeros
// [R16] 53 EF 6E n starts sine test, n gives rate index and skip
// [R17] sine frequency is rate times skip over 128, eight rates
// [R18] 45 78 69 74 and four zeros ends the sine test
// [R19] 50 ED 6E 54 starts pin test, CB 72 6B 54 production test
// [R20] 4D EA 6D 54 starts memory test; result after 200000 cycles
// [R21] memory result: bit 15 done, bit 6 mux, bits 5..0 memories
// [R22] 53 70 EE n copies register n-48 to lower header, else upper
// [R23] test sequences recognised only while test enable bit is set
// [R24] with tests disabled matching bytes remain ordinary stream data
module dstc_top
  import dstc_pkg::*;
#(
  parameter int MEM_TEST_CYCLES = MEM_TEST_CYC
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // serial data link
  input wire logic SDI_CLK,
  input wire logic SDI_DATA,
  input wire logic SDI_CS_N,
  output logic DATA_REQ,
  output logic [7:0] STREAM_BYTE,
  output logic STREAM_VALID,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  // decoder core
  input wire logic CORE_READY,
  input wire logic HDR_LOAD,
  input wire logic [31:0] HDR_WORD,
  input wire logic WAV_ACTIVE,
  input wire logic DECODE_ERROR,
  input wire logic WAV_LEN_VALID,
  input wire logic [31:0] WAV_LEN,
  input wire logic WAV_BITS16,
  input wire logic WAV_STEREO,
  input wire logic [6:0] MEM_RESULT,
  // status
  output logic [16:0] SAMPLE_RATE_HZ,
  output logic [8:0] BITRATE_KBPS,
  output logic STREAM_SYNC_OK,
  output logic [7:0] ATTEN_LEFT,
  output logic [7:0] ATTEN_RIGHT,
  output logic [1:0] CH_SILENT,
  output logic ANALOG_MUTE,
  output logic ANALOG_PWR_OFF,
  output logic PCM_FOREVER,
  output logic PCM_16BIT,
  output logic PCM_STEREO,
  output logic CLOCKS_STOPPED,
  output logic CRYSTAL_GROUND,
  output logic SW_RESET_BUSY,
  // tests
  output logic SINE_ACTIVE,
  output logic [16:0] SINE_RATE_HZ,
  output logic [4:0] SINE_SKIP,
  output logic [14:0] SINE_FREQ_HZ,
  output logic PIN_TEST,
  output logic PROD_TEST,
  output logic MEM_TEST_BUSY
);

  ////////////////////////////////////////////////////////////////////////
  // link side: sync, bit shifting, byte framing

  logic [SYNC_W-1:0] lvl;
  logic sclk_prev_q, sclk_prev_d;
  logic [2:0] bitcnt_q, bitcnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] byte_q, byte_d;
  logic byte_vld_q, byte_vld_d;

  dstc_sync u_sync (
    .clk(CLK),
    .rst(RST),
    .async_in({SDI_CS_N, SDI_DATA, SDI_CLK}),
    .level_out(lvl)
  );

  always_comb
  begin
    sclk_prev_d = lvl[0];
    bitcnt_d = bitcnt_q;
    shift_d = shift_q;
    byte_d = byte_q;
    byte_vld_d = 1'b0;
    if (lvl[2])
      bitcnt_d = 3'd0;
    else if (lvl[0] && !sclk_prev_q)
    begin
      shift_d = {shift_q[6:0], lvl[1]};
      bitcnt_d = bitcnt_q + 3'd1;
      if (bitcnt_q == 3'd7)
      begin
        byte_d = {shift_q[6:0], lvl[1]};
        byte_vld_d = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sclk_prev_q <= 1'b0;
      bitcnt_q <= 3'd0;
      shift_q <= 8'h00;
      byte_q <= 8'h00;
      byte_vld_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_prev_d;
      bitcnt_q <= bitcnt_d;
      shift_q <= shift_d;
      byte_q <= byte_d;
      byte_vld_q <= byte_vld_d;
    end
  end

  // every byte goes to the decoder, test commands or not; see [R24]
  assign STREAM_BYTE = byte_q;
  assign STREAM_VALID = byte_vld_q;

  ////////////////////////////////////////////////////////////////////////
  // command matcher and test state

  logic [15:0] mode_q;
  logic [63:0] hist_q, hist_d;
  logic [63:0] win;
  dstc_test_t test_q, test_d;
  logic [7:0] sine_n_q, sine_n_d;
  logic [MEM_CNT_W-1:0] mem_cnt_q, mem_cnt_d;
  logic mem_done_q, mem_done_d;
  logic copy_go_q, copy_go_d;
  logic [7:0] copy_n_q, copy_n_d;

  assign win = {hist_q[55:0], byte_q};

  always_comb
  begin
    hist_d = hist_q;
    test_d = test_q;
    sine_n_d = sine_n_q;
    mem_cnt_d = mem_cnt_q;
    mem_done_d = 1'b0;
    copy_go_d = 1'b0;
    copy_n_d = copy_n_q;
    if (byte_vld_q)
      hist_d = win;
    if (test_q == TEST_MEM)
    begin
      if (mem_cnt_q == MEM_CNT_W'(MEM_TEST_CYCLES - 1))
      begin
        mem_done_d = 1'b1; // see [R20]
        test_d = TEST_NONE;
      end
      else
        mem_cnt_d = mem_cnt_q + 1'b1;
    end
    // see [R23]
    if (byte_vld_q && mode_q[MODE_TEST_BIT] && win[31:0] == 32'h0000_0000)
    begin
      case (1'b1)
        (win[63:32] == CMD_PIN): test_d = TEST_PIN; // see [R19]
        (win[63:32] == CMD_PROD): test_d = TEST_PROD; // see [R19]
        (win[63:32] == CMD_MEM):
        begin
          test_d = TEST_MEM; // see [R20]
          mem_cnt_d = '0;
        end
        (win[63:40] == CMD_SINE_HEAD):
        begin
          test_d = TEST_SINE; // see [R16]
          sine_n_d = win[39:32];
        end
        (win[63:32] == CMD_SINE_EXIT):
        begin
          if (test_q == TEST_SINE)
            test_d = TEST_NONE; // see [R18]
        end
        (win[63:40] == CMD_COPY_HEAD):
        begin
          copy_go_d = 1'b1; // see [R22]
          copy_n_d = win[39:32];
        end
        default: test_d = test_d;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      hist_q <= 64'h0000_0000_0000_0000;
      test_q <= TEST_NONE;
      sine_n_q <= 8'h00;
      mem_cnt_q <= '0;
      mem_done_q <= 1'b0;
      copy_go_q <= 1'b0;
      copy_n_q <= 8'h00;
    end
    else
    begin
      hist_q <= hist_d;
      test_q <= test_d;
      sine_n_q <= sine_n_d;
      mem_cnt_q <= mem_cnt_d;
      mem_done_q <= mem_done_d;
      copy_go_q <= copy_go_d;
      copy_n_q <= copy_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers, reset timing and status

  logic [15:0] mode_d;
  logic [15:0] hdr_lo_q, hdr_lo_d, hdr_hi_q, hdr_hi_d;
  logic [15:0] atten_q, atten_d;
  logic [15:0] rdata_q, rdata_d;
  logic [12:0] hold_q, hold_d;
  logic data_request_line_q, data_request_line_d;
  logic mute_q, mute_d;
  logic pcm_q, pcm_d, pcm16_q, pcm16_d, pcmst_q, pcmst_d;
  logic stop_q;
  logic [16:0] rate_q, rate_d, srate_q, srate_d;
  logic [8:0] kbps_q, kbps_d;
  logic [14:0] sfreq_q, sfreq_d;
  logic [21:0] sprod;
  logic [7:0] copy_src;
  logic [15:0] copy_val;
  logic sw_rst;

  // visible register value for a given index; see [R5]
  function automatic logic [15:0] view(input logic [3:0] idx);
    case (idx)
      IDX_MODE: view = mode_q;
      IDX_HDR_LOW: view = WAV_ACTIVE ? WAV_LOW : hdr_lo_q;
      IDX_HDR_HIGH: view = WAV_ACTIVE ? WAV_HIGH : hdr_hi_q;
      IDX_ATTEN: view = atten_q;
      default: view = 16'h0000;
    endcase
  endfunction : view

  assign sw_rst = REG_WR && REG_ADDR == IDX_MODE && REG_WDATA[MODE_SWRST_BIT];
  assign copy_src = copy_n_q - COPY_BASE;
  assign sprod = 22'(sine_rate(sine_n_q[7:5])) * 22'(sine_n_q[4:0]);

  always_comb
  begin
    mode_d = mode_q;
    mode_d[MODE_SWRST_BIT] = 1'b0; // bit clears itself
    hdr_lo_d = hdr_lo_q;
    hdr_hi_d = hdr_hi_q;
    atten_d = atten_q;
    rdata_d = rdata_q;
    hold_d = (hold_q != 13'd0) ? hold_q - 13'd1 : hold_q;
    mute_d = mute_q;
    pcm_d = pcm_q;
    pcm16_d = pcm16_q;
    pcmst_d = pcmst_q;
    copy_val = (copy_src[7:4] == 4'h0) ? view(copy_src[3:0]) : 16'h0000;
    if (REG_RD)
      rdata_d = view(REG_ADDR);
    if (REG_WR && REG_ADDR == IDX_MODE)
      mode_d = REG_WDATA;
    if (REG_WR && REG_ADDR == IDX_ATTEN)
      atten_d = REG_WDATA; // see [R8]
    if (HDR_LOAD)
    begin
      hdr_hi_d = HDR_WORD[31:16]; // see [R1]
      hdr_lo_d = HDR_WORD[15:0];
      mute_d = 1'b0;
    end
    if (copy_go_q)
    begin
      if (copy_src == {4'h0, IDX_HDR_LOW})
        hdr_hi_d = copy_val; // see [R22]
      else
        hdr_lo_d = copy_val; // see [R22]
    end
    if (mem_done_q)
      hdr_lo_d = (16'h1 << MEM_DONE_BIT) | {9'h000, MEM_RESULT}; // see [R21]
    if (WAV_LEN_VALID) // see [R14]
    begin
      pcm_d = (WAV_LEN == 32'h0000_0000) || (WAV_LEN == PCM_LEN_FOREVER);
      pcm16_d = WAV_BITS16;
      pcmst_d = WAV_STEREO;
    end
    if (DECODE_ERROR)
    begin
      hdr_lo_d = HDR_RESET; // see [R6]
      hdr_hi_d = HDR_RESET;
      mute_d = 1'b1;
    end
    if (sw_rst)
    begin
      hdr_lo_d = HDR_RESET; // see [R2]
      hdr_hi_d = HDR_RESET;
      hold_d = SWRST_HOLD_CYC; // see [R12]
      mute_d = 1'b0;
      pcm_d = 1'b0;
      // attenuation deliberately untouched; see [R9]
    end
    data_request_line_d = (hold_d == 13'd0) && CORE_READY && !sw_rst; // see [R12]
    rate_d = rate_hz(hdr_hi_q[4:3], hdr_lo_q[11:10]); // see [R3]
    kbps_d = rate_kbps(hdr_hi_q[4:3], hdr_lo_q[15:12]); // see [R4]
    srate_d = sine_rate(sine_n_q[7:5]); // see [R17]
    sfreq_d = sprod[21:SINE_SKIP_SHIFT]; // see [R17]
  end

  // hardware reset returns everything to initial values; see [R11]
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      mode_q <= MODE_RESET;
      hdr_lo_q <= HDR_RESET; // see [R2]
      hdr_hi_q <= HDR_RESET;
      atten_q <= ATTEN_RESET; // see [R9]
      rdata_q <= 16'h0000;
      hold_q <= 13'd0;
      data_request_line_q <= 1'b0;
      mute_q <= 1'b0;
      pcm_q <= 1'b0;
      pcm16_q <= 1'b0;
      pcmst_q <= 1'b0;
      stop_q <= 1'b1; // see [R11]
      rate_q <= 17'h0_0000;
      kbps_q <= 9'h000;
      srate_q <= 17'h0_0000;
      sfreq_q <= 15'h0000;
    end
    else
    begin
      mode_q <= mode_d;
      hdr_lo_q <= hdr_lo_d;
      hdr_hi_q <= hdr_hi_d;
      atten_q <= atten_d;
      rdata_q <= rdata_d;
      hold_q <= hold_d;
      data_request_line_q <= data_request_line_d;
      mute_q <= mute_d;
      pcm_q <= pcm_d;
      pcm16_q <= pcm16_d;
      pcmst_q <= pcmst_d;
      stop_q <= 1'b0;
      rate_q <= rate_d;
      kbps_q <= kbps_d;
      srate_q <= srate_d;
      sfreq_q <= sfreq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign REG_RDATA = rdata_q;
  assign DATA_REQ = data_request_line_q;
  assign SW_RESET_BUSY = hold_q != 13'd0;
  assign SAMPLE_RATE_HZ = rate_q;
  assign BITRATE_KBPS = kbps_q;
  assign STREAM_SYNC_OK = hdr_hi_q[15:5] == SYNC_VALID; // see [R1]
  assign ATTEN_LEFT = atten_q[15:8]; // see [R7]
  assign ATTEN_RIGHT = atten_q[7:0]; // see [R7]
  assign CH_SILENT = {atten_q[15:8] == ATTEN_SILENT,
                      atten_q[7:0] == ATTEN_SILENT};
  assign ANALOG_PWR_OFF = &CH_SILENT; // see [R10]
  assign ANALOG_MUTE = mute_q | ANALOG_PWR_OFF; // see [R6]
  assign PCM_FOREVER = pcm_q;
  assign PCM_16BIT = pcm16_q;
  assign PCM_STEREO = pcmst_q;
  assign CLOCKS_STOPPED = stop_q; // see [R11]
  assign CRYSTAL_GROUND = stop_q; // see [R11]
  assign SINE_ACTIVE = test_q == TEST_SINE;
  assign SINE_RATE_HZ = srate_q;
  assign SINE_SKIP = sine_n_q[4:0];
  assign SINE_FREQ_HZ = sfreq_q;
  assign PIN_TEST = test_q == TEST_PIN;
  assign PROD_TEST = test_q == TEST_PROD;
  assign MEM_TEST_BUSY = test_q == TEST_MEM;

endmodule : dstc_top

// ==== bench/dstc_top_assertions.sv ====
// dstc_top_assertions: port checks for the status block
// assumes it is bound to dstc_top and sees only its ports
module dstc_top_assertions
  import dstc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  // core and status
  input wire logic WAV_ACTIVE,
  input wire logic DECODE_ERROR,
  input wire logic DATA_REQ,
  input wire logic STREAM_SYNC_OK,
  input wire logic ANALOG_MUTE,
  input wire logic ANALOG_PWR_OFF,
  input wire logic [7:0] ATTEN_LEFT,
  input wire logic CLOCKS_STOPPED,
  input wire logic CRYSTAL_GROUND,
  // tests
  input wire logic SINE_ACTIVE,
  input wire logic PIN_TEST,
  input wire logic PROD_TEST,
  input wire logic MEM_TEST_BUSY
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [15:0] since_d, since_q;
  logic tst_d, tst_q, sw_wr;
  logic [7:0] wr_left;
  assign sw_wr = REG_WR && REG_ADDR == IDX_MODE && REG_WDATA[MODE_SWRST_BIT];
  assign wr_left = REG_WDATA[15:8];
  // cycles since software reset, test enable as last written
  always_comb
  begin
    since_d = since_q;
    tst_d = tst_q;
    if (sw_wr)
      since_d = 16'h0000;
    else if (since_q != 16'hFFFF)
      since_d = since_q + 16'h0001;
    if (REG_WR && REG_ADDR == IDX_MODE)
      tst_d = REG_WDATA[MODE_TEST_BIT];
  end
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      since_q <= 16'hFFFF;
      tst_q <= 1'b0;
    end
    else
    begin
      since_q <= since_d;
      tst_q <= tst_d;
    end
  end
  ////////////////////////////////////////
  sequence sw_write;
    sw_wr;
  endsequence
  sequence req_low;
    !DATA_REQ [*8];
  endsequence
  chk_swrst_low: assert property (sw_write |=> req_low)
    else $error("data request not low after software reset");
  chk_swrst_hold: assert property ($rose(DATA_REQ) |-> since_q >= 16'h1770)
    else $error("data request rose too early");
  chk_wav_low: assert property (WAV_ACTIVE && REG_RD && REG_ADDR == IDX_HDR_LOW
    |=> REG_RDATA == WAV_LOW)
    else $error("header low not fixed during wav");
  chk_atten_left: assert property (REG_WR && REG_ADDR == IDX_ATTEN
    |=> ATTEN_LEFT == $past(wr_left))
    else $error("left attenuation not upper byte");
  chk_pwr_off: assert property (REG_WR && REG_ADDR == IDX_ATTEN
    && REG_WDATA == 16'hFFFF |=> ##[0:1] (ANALOG_PWR_OFF && ANALOG_MUTE))
    else $error("analog power not off at silence");
  chk_err_clear: assert property (DECODE_ERROR
    |=> ##[0:1] (!STREAM_SYNC_OK && ANALOG_MUTE))
    else $error("error did not clear header and mute");
  chk_reset_exit: assert property ($fell(RST)
    |=> !CLOCKS_STOPPED && !CRYSTAL_GROUND)
    else $error("clocks still stopped after reset");
  chk_test_gate: assert property ($rose(SINE_ACTIVE) || $rose(PIN_TEST)
    || $rose(PROD_TEST) || $rose(MEM_TEST_BUSY) |-> tst_q)
    else $error("test entered while tests disabled");
endmodule : dstc_top_assertions

bind dstc_top dstc_top_assertions chk_u (.CLK, .RST, .REG_ADDR, .REG_WR,
  .REG_RD, .REG_WDATA, .REG_RDATA, .WAV_ACTIVE, .DECODE_ERROR, .DATA_REQ,
  .STREAM_SYNC_OK, .ANALOG_MUTE, .ANALOG_PWR_OFF, .ATTEN_LEFT,
  .CLOCKS_STOPPED, .CRYSTAL_GROUND, .SINE_ACTIVE, .PIN_TEST, .PROD_TEST,
  .MEM_TEST_BUSY);

// ==== bench/dstc_host_model.sv ====
// dstc_host_model: host driving the serial data link
// assumes the bench calls send_cmd, 48 ns bit period
module dstc_host_model
(
  // serial data link
  output logic sdi_clk,
  output logic sdi_data,
  output logic sdi_cs_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sdi_clk = 1'b0;
    sdi_data = 1'b1;
    sdi_cs_n = 1'b1;
  end
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sdi_data = b[i];
      #12 sdi_clk = 1'b1;
      #24 sdi_clk = 1'b0;
      #12;
    end
  endtask : send_byte
  // command word then four zero bytes in one frame
  task automatic send_cmd(input logic [31:0] c);
    sdi_cs_n = 1'b0;
    #24;
    for (int k = 3; k >= 0; k--)
      send_byte(c[8*k +: 8]);
    for (int k = 0; k < 4; k++)
      send_byte(8'h00);
    #24 sdi_cs_n = 1'b1;
    sdi_data = ~sdi_data;
  endtask : send_cmd
endmodule : dstc_host_model

// ==== bench/dstc_top_test.sv ====
// dstc_top_test: directed bench for header, volume, reset and tests
// assumes a short memory test and the serial host model
module dstc_top_test
  import dstc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, RST, REG_WR, REG_RD, HDR_LOAD, WAV_ACTIVE, DECODE_ERROR;
  logic CORE_READY, WAV_LEN_VALID, WAV_BITS16, WAV_STEREO, DATA_REQ;
  logic STREAM_SYNC_OK, ANALOG_MUTE, ANALOG_PWR_OFF, PCM_FOREVER, PCM_16BIT;
  logic PCM_STEREO, CLOCKS_STOPPED, CRYSTAL_GROUND, SINE_ACTIVE, PIN_TEST;
  logic PROD_TEST, MEM_TEST_BUSY, STREAM_VALID, SW_RESET_BUSY;
  logic [3:0] REG_ADDR, test_state;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic [31:0] HDR_WORD, WAV_LEN;
  logic [6:0] MEM_RESULT;
  logic [16:0] SAMPLE_RATE_HZ, SINE_RATE_HZ;
  logic [8:0] BITRATE_KBPS;
  logic [7:0] ATTEN_LEFT, ATTEN_RIGHT, STREAM_BYTE;
  logic [1:0] CH_SILENT;
  logic [4:0] SINE_SKIP;
  logic [14:0] SINE_FREQ_HZ;
  wire SDI_CLK, SDI_DATA, SDI_CS_N;
  int mismatches, check_count, n, nbytes;
  int fs[8] = '{44100, 48000, 32000, 22050, 24000, 16000, 11025, 12000};
  int br_hi[16] = '{0, 32, 40, 48, 56, 64, 80, 96, 112, 128, 160, 192, 224,
    256, 320, 0};
  int br_lo[16] = '{0, 8, 16, 24, 32, 40, 48, 56, 64, 80, 96, 112, 128, 144,
    160, 0};
  logic [15:0] vol[4] = '{16'h0407, 16'h00FF, 16'hBF00, 16'hFFFF};
  logic [31:0] lens[3] = '{32'h0000_0000, 32'h0000_0005, 32'h0FFF_FFFF};
  logic [31:0] starts[4] = '{32'h53EF_6E7E, 32'h50ED_6E54, 32'hCB72_6B54,
    32'h4DEA_6D54};
  assign test_state = {SINE_ACTIVE, PIN_TEST, PROD_TEST, MEM_TEST_BUSY};
  always @(negedge CLK) nbytes += int'(STREAM_VALID);
  dstc_host_model host_u (.sdi_clk(SDI_CLK), .sdi_data(SDI_DATA),
    .sdi_cs_n(SDI_CS_N));
  dstc_top #(.MEM_TEST_CYCLES(50)) dut_u (.CLK, .RST, .SDI_CLK, .SDI_DATA,
    .SDI_CS_N, .DATA_REQ, .STREAM_BYTE, .STREAM_VALID, .REG_ADDR,
    .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .CORE_READY, .HDR_LOAD,
    .HDR_WORD, .WAV_ACTIVE, .DECODE_ERROR, .WAV_LEN_VALID, .WAV_LEN,
    .WAV_BITS16, .WAV_STEREO, .MEM_RESULT, .SAMPLE_RATE_HZ, .BITRATE_KBPS,
    .STREAM_SYNC_OK, .ATTEN_LEFT, .ATTEN_RIGHT, .CH_SILENT, .ANALOG_MUTE,
    .ANALOG_PWR_OFF, .PCM_FOREVER, .PCM_16BIT, .PCM_STEREO, .CLOCKS_STOPPED,
    .CRYSTAL_GROUND, .SW_RESET_BUSY, .SINE_ACTIVE, .SINE_RATE_HZ,
    .SINE_SKIP, .SINE_FREQ_HZ, .PIN_TEST, .PROD_TEST, .MEM_TEST_BUSY);
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
    @(negedge CLK);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(negedge CLK);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK);
    REG_RD = 1'b0;
    check(REG_RDATA, e);
  endtask : rd
  task automatic hw_reset;
    @(negedge CLK);
    RST = 1'b1;
    repeat (10) @(negedge CLK);
    check({CLOCKS_STOPPED, CRYSTAL_GROUND}, 2'b11);
    RST = 1'b0;
    repeat (2) @(negedge CLK);
  endtask : hw_reset
  task automatic cmd(input logic [31:0] c);
    host_u.send_cmd(c);
    repeat (12) @(negedge CLK);
  endtask : cmd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial
  begin
    #300000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
  initial
  begin
    {RST, REG_WR, REG_RD, HDR_LOAD, WAV_ACTIVE, DECODE_ERROR} = 6'h20;
    {WAV_LEN_VALID, WAV_BITS16, WAV_STEREO, CORE_READY} = 4'h1;
    {REG_ADDR, REG_WDATA, HDR_WORD, WAV_LEN} = '0;
    MEM_RESULT = 7'h55;
    hw_reset();
    rd(IDX_HDR_LOW, 16'h0000);
    rd(IDX_HDR_HIGH, 16'h0000);
    rd(IDX_ATTEN, 16'h0000);
    rd(4'h3, 16'h0000);
    $display("test reset done");
    for (int v = 0; v < 4; v++)
      for (int c = 0; c < 16; c++)
      begin
        HDR_WORD = {11'h7FF, v[1:0], 3'b011, c[3:0], c[1:0], 10'h000};
        HDR_LOAD = 1'b1;
        @(negedge CLK);
        HDR_LOAD = 1'b0;
        repeat (2) @(negedge CLK);
        n = (c % 4 == 3) ? 0 : fs[c % 4] >> (v == 3 ? 0 : (v == 2 ? 1 : 2));
        check(SAMPLE_RATE_HZ, n);
        check(BITRATE_KBPS, v == 3 ? br_hi[c] : br_lo[c]);
        check(STREAM_SYNC_OK, 1'b1);
      end
    rd(IDX_HDR_HIGH, 16'hFFFB);
    rd(IDX_HDR_LOW, 16'hFC00);
    WAV_ACTIVE = 1'b1;
    rd(IDX_HDR_LOW, WAV_LOW);
    rd(IDX_HDR_HIGH, WAV_HIGH);
    WAV_ACTIVE = 1'b0;
    DECODE_ERROR = 1'b1;
    @(negedge CLK);
    DECODE_ERROR = 1'b0;
    rd(IDX_HDR_HIGH, 16'h0000);
    check(ANALOG_MUTE, 1'b1);
    wr(IDX_HDR_LOW, 16'h1234);
    rd(IDX_HDR_LOW, 16'h0000);
    $display("test header done");
    foreach (vol[i])
    begin
      wr(IDX_ATTEN, vol[i]);
      check({ATTEN_LEFT, ATTEN_RIGHT}, vol[i]);
      check(CH_SILENT, {vol[i][15:8] == 8'hFF, vol[i][7:0] == 8'hFF});
      check(ANALOG_PWR_OFF, vol[i] == 16'hFFFF);
    end
    wr(IDX_MODE, 16'h0004);
    check({DATA_REQ, SW_RESET_BUSY}, 2'b01);
    n = 0;
    while (DATA_REQ !== 1'b1 && n < 7000)
    begin
      @(negedge CLK);
      n++;
    end
    check(n + 1 >= 6000 && n < 6100, 1'b1);
    rd(IDX_ATTEN, 16'hFFFF);
    $display("test volume and reset done");
    foreach (lens[i])
    begin
      {WAV_LEN, WAV_BITS16, WAV_STEREO, WAV_LEN_VALID} = {lens[i], i[1:0], 1'b1};
      @(negedge CLK);
      WAV_LEN_VALID = 1'b0;
      @(negedge CLK);
      check(PCM_FOREVER, lens[i] != 32'h0000_0005);
      check({PCM_16BIT, PCM_STEREO}, i[1:0]);
    end
    foreach (starts[i])
    begin
      cmd(starts[i]);
      check({STREAM_BYTE, test_state}, 12'h000);
    end
    check(nbytes, 32);
    foreach (starts[i])
    begin
      hw_reset();
      wr(IDX_MODE, 16'h0020);
      cmd(starts[i]);
      check(test_state, 4'h8 >> i);
    end
    n = 0;
    while (MEM_TEST_BUSY === 1'b1 && n < 200)
    begin
      @(negedge CLK);
      n++;
    end
    rd(IDX_HDR_LOW, {9'h100, MEM_RESULT});
    $display("test start commands done");
    for (int i = 0; i < 8; i++)
    begin
      cmd({24'h53_EF6E, i[2:0], 5'h1E});
      check({SINE_ACTIVE, SINE_RATE_HZ, SINE_SKIP}, {1'b1, fs[i][16:0], 5'h1E});
      check(SINE_FREQ_HZ, fs[i] * 30 / 128);
      cmd(32'h4578_6974);
      check(SINE_ACTIVE, 1'b0);
    end
    wr(IDX_ATTEN, 16'h1234);
    cmd({24'h53_70EE, 8'h3B});
    rd(IDX_HDR_LOW, 16'h1234);
    cmd({24'h53_70EE, 8'h38});
    rd(IDX_HDR_HIGH, 16'h1234);
    $display("test sine and copy done");
    wrap_up();
  end
endmodule : dstc_top_test
